// *** design/ppx_exec.sv ***
// Instruction executor: load, store, add, shift, logical and replace steps.
module ppx_exec (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [ppx_pkg::WORD_W-1:0] mem_addr_o,
  output logic             mem_re_o,
  output logic             mem_we_o,
  output logic      [ppx_pkg::WORD_W-1:0] mem_wdata_o,
  input  wire logic [ppx_pkg::WORD_W-1:0] mem_rdata_i,
  output logic      [ppx_pkg::K_W-1:0]    k_o,
  output logic             busy_o
);
  import ppx_pkg::*;

  // ==========================================================================
  // State
  ppx_state_e              state_reg;
  ppx_state_e              state_next;
  logic [1:0]              ph_reg;
  logic [FLD_W-1:0]        op_reg;
  logic [TRIP_W-1:0]       trip_reg;
  logic [FLD_W-1:0]        d_reg;
  logic [WORD_W-1:0]       m_reg;
  logic [WORD_W-1:0]       dval_reg;
  logic [WORD_W-1:0]       opnd_reg;
  logic [ACC_W-1:0]        acc_reg;
  logic [ACC_W-1:0]        acc_next;
  logic [WORD_W-1:0]       paddr_reg;
  logic                    run_reg;
  logic                    wr_en;
  logic [WORD_W-1:0]       wr_data;
  logic [WORD_W-1:0]       eff_addr;
  logic [WORD_W-1:0]       rd_addr;
  logic                    rd_state;
  logic                    cap;
  logic [2:0]              fam;
  logic [2:0]              act;
  logic                    mem_op;
  logic                    is_long;
  logic                    needs_d;
  logic                    needs_opnd;
  logic                    wb_req;
  logic                    wb_wr;
  logic [17:0]             long_val;
  logic [17:0]             sum18;
  logic [11:0]             step12;
  logic [4:0]              rot_n;
  logic [5:0]              rsh_n;

  assign fam        = op_reg[5:3];
  assign act        = op_reg[2:0];
  assign mem_op     = (fam == FAM_DIRECT) || (fam == FAM_INDIRECT) ||
                      (fam == FAM_INDEXED);
  assign is_long    = (op_reg == OP_LOAD_LONG_IMM) ||
                      (op_reg == OP_ADD_LONG_IMM) ||
                      (op_reg == OP_AND_LONG_IMM) ||
                      (op_reg == OP_XOR_LONG_IMM) || (fam == FAM_INDEXED);
  assign needs_d    = (fam == FAM_INDIRECT) ||
                      ((fam == FAM_INDEXED) && (d_reg != '0));
  assign needs_opnd = mem_op && (act != ACT_STORE);
  assign long_val   = {d_reg, m_reg};
  assign rd_state   = (state_reg == ST_FETCH) || (state_reg == ST_MREAD) ||
                      (state_reg == ST_DREAD) || (state_reg == ST_OREAD);
  assign cap        = rd_state && (ph_reg == 2'h2);
  assign wb_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr      = wb_req && wb_we_i && wb_sel_i[0];

  // ==========================================================================
  // Operand address
  always_comb begin
    case (fam)
      FAM_INDIRECT: eff_addr = dval_reg;
      FAM_INDEXED:  eff_addr = (d_reg == '0) ? m_reg :
                               ppx_add12(m_reg, dval_reg);
      default:      eff_addr = {6'h00, d_reg};
    endcase
  end

  always_comb begin
    case (state_reg)
      ST_FETCH: rd_addr = paddr_reg;
      ST_MREAD: rd_addr = paddr_reg;
      ST_DREAD: rd_addr = {6'h00, d_reg};
      default:  rd_addr = eff_addr;
    endcase
  end

  // ==========================================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:   if (run_reg) state_next = ST_FETCH;
      ST_FETCH:  if (cap) state_next = ST_DECODE;
      ST_DECODE: begin
        if (is_long) state_next = ST_MREAD;
        else if (needs_d) state_next = ST_DREAD;
        else if (needs_opnd) state_next = ST_OREAD;
        else state_next = ST_EXEC;
      end
      ST_MREAD: begin
        if (cap) begin
          if (needs_d) state_next = ST_DREAD;
          else if (needs_opnd) state_next = ST_OREAD;
          else state_next = ST_EXEC;
        end
      end
      ST_DREAD: begin
        if (cap) state_next = needs_opnd ? ST_OREAD : ST_EXEC;
      end
      ST_OREAD:  if (cap) state_next = ST_EXEC;
      ST_EXEC:   state_next = wr_en ? ST_WRITE : ST_IDLE;
      ST_WRITE:  state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      ph_reg    <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (!rd_state || cap) ph_reg <= 2'h0;
      else ph_reg <= ph_reg + 2'h1;
    end
  end

  // Control word: opcode captured at fetch, trip counts each later read and the execute step.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_reg   <= '0;
      d_reg    <= '0;
      trip_reg <= '0;
    end else if (cap && state_reg == ST_FETCH) begin
      op_reg   <= mem_rdata_i[11:6];
      d_reg    <= mem_rdata_i[5:0];
      trip_reg <= '0;
    end else if (cap || state_reg == ST_EXEC) begin
      trip_reg <= trip_reg + 3'h1;
    end
  end

  // Words read during the instruction.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m_reg    <= '0;
      dval_reg <= '0;
      opnd_reg <= '0;
    end else if (cap) begin
      if (state_reg == ST_MREAD) m_reg <= mem_rdata_i;
      if (state_reg == ST_DREAD) dval_reg <= mem_rdata_i;
      if (state_reg == ST_OREAD) opnd_reg <= mem_rdata_i;
    end
  end

  // Program address advances at fetch and over the second word.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      paddr_reg <= PADDR_RESET;
    end else if (cap && (state_reg == ST_FETCH || state_reg == ST_MREAD)) begin
      paddr_reg <= paddr_reg + WORD_ONE;
    end else if (wb_wr && wb_adr_i == REG_PADDR && state_reg == ST_IDLE) begin
      paddr_reg <= wb_dat_i[WORD_W-1:0];
    end
  end

  // ==========================================================================
  // Execution datapath
  assign rot_n = d_reg[4:0];
  assign rsh_n = ~d_reg;

  always_comb begin
    acc_next = acc_reg;
    wr_en    = 1'b0;
    wr_data  = acc_reg[11:0];
    sum18    = ppx_add18(acc_reg, {6'h00, opnd_reg});
    step12   = ppx_add12(opnd_reg, (act == ACT_RINC) ? WORD_ONE : ~WORD_ONE);
    if (mem_op) begin
      case (act)
        ACT_LOAD:  acc_next = {6'h00, opnd_reg};
        ACT_ADD:   acc_next = sum18;
        ACT_SUB:   acc_next = ppx_add18(acc_reg,
                                        ~{6'h00, opnd_reg});
        ACT_XOR:   acc_next = {acc_reg[17:12],
                               acc_reg[11:0] ^ opnd_reg};
        ACT_STORE: wr_en = 1'b1;
        ACT_RADD: begin
          acc_next = sum18;
          wr_en    = 1'b1;
          wr_data  = sum18[11:0];
        end
        default: begin
          acc_next = {6'h00, step12};
          wr_en    = 1'b1;
          wr_data  = step12;
        end
      endcase
    end else begin
      case (op_reg)
        OP_SHIFT_BY_COUNT: begin
          if ((d_reg & SHIFT_RIGHT_BIT) == '0) begin
            for (int i = 0; i < 31; i++) begin
              if (i < int'(rot_n)) acc_next = {acc_next[16:0], acc_next[17]};
            end
          end else begin
            acc_next = acc_reg >> rsh_n;
          end
        end
        OP_XOR_SHORT_IMM:   acc_next = {acc_reg[17:6],
                                        acc_reg[5:0] ^ d_reg};
        OP_AND_SHORT_IMM:   acc_next = {12'h000,
                                        acc_reg[5:0] & d_reg};
        OP_CLEAR_SELECTED:  acc_next = {acc_reg[17:6],
                                        acc_reg[5:0] & ~d_reg};
        OP_LOAD_SHORT_IMM:  acc_next = {12'h000, d_reg};
        OP_LOAD_COMPL_SHORT: acc_next = {12'hfff, ~d_reg};
        OP_ADD_SHORT_IMM:   acc_next = ppx_add18(acc_reg,
                                                 {12'h000, d_reg});
        OP_SUB_SHORT_IMM:   acc_next = ppx_add18(acc_reg,
                                                 ~{12'h000, d_reg});
        OP_LOAD_LONG_IMM:   acc_next = long_val;
        OP_ADD_LONG_IMM:    acc_next = ppx_add18(acc_reg, long_val);
        OP_AND_LONG_IMM:    acc_next = acc_reg & long_val;
        OP_XOR_LONG_IMM:    acc_next = acc_reg ^ long_val;
        default:            acc_next = acc_reg;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_reg <= ACC_RESET;
    end else if (state_reg == ST_EXEC) begin
      acc_reg <= acc_next;
    end else if (wb_wr && wb_adr_i == REG_ACC && state_reg == ST_IDLE) begin
      acc_reg <= wb_dat_i[ACC_W-1:0];
    end
  end

  // ==========================================================================
  // Local memory port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_addr_o  <= '0;
      mem_re_o    <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_wdata_o <= '0;
    end else begin
      mem_re_o <= rd_state && (ph_reg == 2'h0);
      mem_we_o <= (state_reg == ST_EXEC) && wr_en;
      if (rd_state && ph_reg == 2'h0) begin
        mem_addr_o <= rd_addr;
      end else if (state_reg == ST_EXEC && wr_en) begin
        mem_addr_o  <= eff_addr;
        mem_wdata_o <= wr_data;
      end
    end
  end

  // ==========================================================================
  // Wishbone slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= 1'b0;
    end else if (wb_wr && wb_adr_i == REG_CTRL) begin
      run_reg <= wb_dat_i[CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        case (wb_adr_i)
          REG_CTRL:   wb_dat_o <= {31'h00000000, run_reg};
          REG_STATUS: wb_dat_o <= {22'h000000, state_reg != ST_IDLE,
                                   op_reg, trip_reg};
          REG_PADDR:  wb_dat_o <= {20'h00000, paddr_reg};
          REG_ACC:    wb_dat_o <= {14'h0000, acc_reg};
          default:    wb_dat_o <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      k_o    <= '0;
      busy_o <= 1'b0;
    end else begin
      k_o    <= {op_reg, trip_reg};
      busy_o <= (state_next != ST_IDLE);
    end
  end

endmodule // ppx_exec

// *** design/ppx_pkg.sv ***
// Constants, opcodes, register map and helper functions for the executor.
// ==========================================================================
// Operation
// - Keep a 9-bit control word: 6-bit opcode plus 3-bit trip count.
// - Opcode 14 loads the short field into a cleared accumulator.
// - Opcode 15 loads complemented field, upper 12 accumulator bits ones.
// - Opcode 30 loads the word at field address, upper six bits zero.
// - Indirect load reads a pointer at the field address, then operand.
// - Long load forms field as high six bits over the next program word.
// - Indexed address is the next word, plus word at field when nonzero.
// - Stores 34, 44, 54 write low 12 accumulator bits to memory.
// - Opcodes 16 and 17 add or subtract the unsigned short field.
// - Opcodes 31 and 32 add or subtract the word at field address.
// - Indirect and indexed add or subtract an unsigned 12-bit operand.
// - Opcode 21 adds the 18-bit field-and-next-word value.
// - Shift: counts 00-37 rotate left, 40-77 shift right by complement.
// - Opcode 11 XORs the field into low six bits, upper kept.
// - Short AND keeps low six bits ANDed, upper 12 bits cleared.
// - Opcode 13 clears low bits where the field has ones.
// - Memory XOR forms into low 12 bits, upper six bits kept.
// - Opcode 22 ANDs the whole accumulator with the 18-bit long value.
// - Opcode 23 XORs the whole accumulator with the 18-bit long value.
// - Opcode 35 adds word to accumulator and writes low sum bits back.
// - Increment and decrement in place write back and load the result.
// - Opcode 45 replace-adds through the indirect operand address.
// - Accumulator adds with end-around carry, no overflow, zero-filled.
// - Program address advances by one as each instruction starts.
package ppx_pkg;

  localparam int ACC_W  = 18;
  localparam int WORD_W = 12;
  localparam int FLD_W  = 6;
  localparam int TRIP_W = 3;
  localparam int K_W    = FLD_W + TRIP_W;

  // Short and long opcodes outside the memory families.
  localparam logic [5:0] OP_SHIFT_BY_COUNT     = 6'h08;
  localparam logic [5:0] OP_XOR_SHORT_IMM      = 6'h09;
  localparam logic [5:0] OP_AND_SHORT_IMM      = 6'h0a;
  localparam logic [5:0] OP_CLEAR_SELECTED     = 6'h0b;
  localparam logic [5:0] OP_LOAD_SHORT_IMM     = 6'h0c;
  localparam logic [5:0] OP_LOAD_COMPL_SHORT   = 6'h0d;
  localparam logic [5:0] OP_ADD_SHORT_IMM      = 6'h0e;
  localparam logic [5:0] OP_SUB_SHORT_IMM      = 6'h0f;
  localparam logic [5:0] OP_LOAD_LONG_IMM      = 6'h10;
  localparam logic [5:0] OP_ADD_LONG_IMM       = 6'h11;
  localparam logic [5:0] OP_AND_LONG_IMM       = 6'h12;
  localparam logic [5:0] OP_XOR_LONG_IMM       = 6'h13;

  // Memory families: opcode bits 5:3 give the mode, bits 2:0 the action.
  localparam logic [2:0] FAM_DIRECT   = 3'h3;
  localparam logic [2:0] FAM_INDIRECT = 3'h4;
  localparam logic [2:0] FAM_INDEXED  = 3'h5;
  localparam logic [2:0] ACT_LOAD     = 3'h0;
  localparam logic [2:0] ACT_ADD      = 3'h1;
  localparam logic [2:0] ACT_SUB      = 3'h2;
  localparam logic [2:0] ACT_XOR      = 3'h3;
  localparam logic [2:0] ACT_STORE    = 3'h4;
  localparam logic [2:0] ACT_RADD     = 3'h5;
  localparam logic [2:0] ACT_RINC     = 3'h6;
  localparam logic [2:0] ACT_RDEC     = 3'h7;
  localparam logic [5:0] SHIFT_RIGHT_BIT = 6'h20;

  // Wishbone register byte offsets.
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PADDR  = 4'h8;
  localparam logic [3:0] REG_ACC    = 4'hc;
  localparam int CTRL_RUN_BIT   = 0;
  localparam int STATUS_BUSY_BIT = 9;

  localparam logic [17:0] ACC_RESET  = 18'h00000;
  localparam logic [11:0] PADDR_RESET = 12'h000;
  localparam logic [11:0] WORD_ONE   = 12'h001;

  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_DECODE, ST_MREAD, ST_DREAD, ST_OREAD,
    ST_EXEC, ST_WRITE
  } ppx_state_e;

  // One's complement 18-bit add with end-around carry.
  function automatic logic [17:0] ppx_add18(input logic [17:0] a,
                                            input logic [17:0] b);
    logic [18:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[17:0] + {17'h00000, s[18]};
  endfunction

  // One's complement 12-bit add with end-around carry.
  function automatic logic [11:0] ppx_add12(input logic [11:0] a,
                                            input logic [11:0] b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[11:0] + {11'h000, s[12]};
  endfunction

endpackage

// *** test/ppx_exec_assertions.sv ***
// Handshake and sequencing checker for the executor ports.
module ppx_exec_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       mem_re_o,
  input wire logic       mem_we_o,
  input wire logic [8:0] k_o,
  input wire logic       busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ========================================================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_due: assert property (p_ack_due) else $error("ack missing");
  property p_re_pulse; mem_re_o |=> !mem_re_o; endproperty
  a_re_pulse: assert property (p_re_pulse) else $error("read too long");
  property p_we_pulse; mem_we_o |=> !mem_we_o; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write long");
  property p_rw_excl; !(mem_re_o && mem_we_o); endproperty
  a_rw_excl: assert property (p_rw_excl) else $error("read and write");
  property p_trip_step;
    k_o[2:0] != $past(k_o[2:0]) && k_o[2:0] != 3'h0
      |-> k_o[2:0] == $past(k_o[2:0]) + 3'h1;
  endproperty
  a_trip_step: assert property (p_trip_step) else $error("trip jump");
  property p_busy_gap; busy_o |-> ##[1:40] !busy_o; endproperty
  a_busy_gap: assert property (p_busy_gap) else $error("busy stuck");
  property p_rst_quiet;
    disable iff (1'b0) rst_i |=> !wb_ack_o && !mem_re_o && !mem_we_o
      && !busy_o && k_o == 9'h000;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset out");
endmodule // ppx_exec_checker

bind ppx_exec ppx_exec_checker u_ppx_exec_checker (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .mem_re_o, .mem_we_o, .k_o, .busy_o
);

// *** test/ppx_mem.sv ***
// Local memory model: synchronous read with one cycle of latency.
module ppx_mem (
  input  wire logic        clk_i,
  input  wire logic        re_i,
  input  wire logic        we_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [11:0] wdata_i,
  output logic      [11:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ========================================================================
  // Storage
  logic [11:0] mem [4096];
  initial begin
    rdata_o = 12'h000;
    foreach (mem[i]) mem[i] = 12'h000;
  end
  // Read data holds until the next read strobe.
  always @(posedge clk_i) begin
    if (re_i) rdata_o <= mem[addr_i];
    if (we_i) mem[addr_i] <= wdata_i;
  end
endmodule // ppx_mem

// *** test/testbench.sv ***
// Self-checking bench for the executor and its local memory.
module testbench import ppx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ========================================================================
  // Table, signals and instances
  typedef struct packed {logic [11:0] w; logic [17:0] a; logic [17:0] x;
                         logic [11:0] ca; logic [11:0] cd;} ppx_row_s;
  ppx_row_s rows [28] = '{
    '{12'h315,18'h00123,18'h00015,12'h015,12'h050},
    '{12'h355,18'h00123,18'h3ffea,12'h015,12'h050},
    '{12'h615,18'h3f123,18'h00050,12'h015,12'h050},
    '{12'h815,18'h3f123,18'h007fe,12'h015,12'h050},
    '{12'h415,18'h00123,18'h15200,12'h015,12'h050},
    '{12'ha15,18'h3f123,18'h00234,12'h015,12'h050},
    '{12'h715,18'h3f123,18'h3f123,12'h015,12'h123},
    '{12'h915,18'h3f123,18'h3f123,12'h050,12'h123},
    '{12'hb15,18'h3f123,18'h3f123,12'h250,12'h123},
    '{12'h3d5,18'h00123,18'h0010e,12'h015,12'h050},
    '{12'h695,18'h00123,18'h000d3,12'h015,12'h050},
    '{12'ha55,18'h00123,18'h00357,12'h015,12'h050},
    '{12'h455,18'h00123,18'h15323,12'h015,12'h050},
    '{12'h215,18'h3f123,18'h3891f,12'h015,12'h050},
    '{12'h239,18'h3f123,18'h00fc4,12'h015,12'h050},
    '{12'h255,18'h3f123,18'h3f136,12'h015,12'h050},
    '{12'h295,18'h3f123,18'h00001,12'h015,12'h050},
    '{12'h2d5,18'h3f123,18'h3f122,12'h015,12'h050},
    '{12'h6d5,18'h3f123,18'h3f173,12'h015,12'h050},
    '{12'h495,18'h3f123,18'h15000,12'h015,12'h050},
    '{12'h4d5,18'h3f123,18'h2a323,12'h015,12'h050},
    '{12'h755,18'h00123,18'h00173,12'h015,12'h173},
    '{12'h795,18'h00123,18'h00051,12'h015,12'h051},
    '{12'h955,18'h00123,18'h00921,12'h050,12'h921},
    '{12'h395,18'h00123,18'h00138,12'h015,12'h050},
    '{12'h655,18'h00123,18'h00173,12'h015,12'h050},
    '{12'h7d5,18'h00123,18'h0004f,12'h015,12'h04f},
    '{12'ha00,18'h3f123,18'h002aa,12'h015,12'h050}
  };
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, q, wb_dat_o;
  logic        wb_ack_o, mem_re_o, mem_we_o, busy_o;
  logic [11:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic [8:0]  k_o;
  int          fail_count = 0, total_checks = 0;
  always #50 clk_i = ~clk_i;
  ppx_exec u_ppx_exec (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o, .wb_ack_o, .mem_addr_o, .mem_re_o, .mem_we_o, .mem_wdata_o,
    .mem_rdata_i, .k_o, .busy_o);
  ppx_mem u_ppx_mem (.clk_i, .re_i(mem_re_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) fail_count++;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  // Waits for busy high (m 0), opcode op in k (m 1) or busy low (m 2).
  task automatic wt(input int m, input logic [5:0] op);
    int n;
    n = 0;
    while (n < 200 && !(m == 0 ? busy_o === 1'b1 :
           m == 1 ? k_o[8:3] === op : busy_o === 1'b0)) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) fail_count++;
  endtask
  // Clears run while the first instruction is still early, so exactly one
  // runs; with drop set it tries a refused write of A and runs on until
  // opcode op is under way, then stops after that one.
  task automatic go(input logic [5:0] op, input logic drop);
    wb(REG_CTRL, 1'b1, 32'h1);
    wt(0, op);
    if (drop) begin
      wb(REG_ACC, 1'b1, 32'h3ffff);
      wt(1, op);
    end
    wb(REG_CTRL, 1'b1, 32'h0);
    wt(2, op);
  endtask
  task automatic setup(input logic [11:0] w, input logic [17:0] a);
    u_ppx_mem.mem[12'h015] = 12'h050;
    u_ppx_mem.mem[12'h050] = 12'h7fe;
    u_ppx_mem.mem[12'h250] = 12'h234;
    u_ppx_mem.mem[12'h100] = w;
    u_ppx_mem.mem[12'h101] = 12'h200;
    u_ppx_mem.mem[12'h200] = 12'h2aa;
    wb(REG_ACC, 1'b1, {14'h0, a});
    wb(REG_PADDR, 1'b1, 32'h100);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin : main
    logic tw;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_STATUS, 32'h0);
    rd(REG_ACC, 32'h0);
    rd(REG_PADDR, 32'h0);
    rd(4'h2, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      setup(rows[i].w, rows[i].a);
      go(rows[i].w[11:6], 1'b0);
      tw = rows[i].w[11:8] == 4'h4 || rows[i].w[11:9] == 3'h5;
      rd(REG_ACC, {14'h0, rows[i].x});
      chk({20'h0, u_ppx_mem.mem[rows[i].ca]}, {20'h0, rows[i].cd});
      rd(REG_PADDR, {20'h0, 12'h101 + {11'h0, tw}});
      $display("row %0d done", i);
    end
    // Replace add then load of the same word, with a refused write of A.
    setup(12'h755, 18'h00123);
    u_ppx_mem.mem[12'h101] = 12'h615;
    go(6'h18, 1'b1);
    rd(REG_ACC, 32'h173);
    rd(REG_STATUS, 32'h0c2);
    chk({20'h0, u_ppx_mem.mem[12'h015]}, 32'h173);
    rd(REG_PADDR, 32'h102);
    $display("replace then load done");
    // Reset in mid-instruction returns every register to its reset value.
    setup(12'h315, 18'h00123);
    wb(REG_CTRL, 1'b1, 32'h1);
    wt(0, 6'h00);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_STATUS, 32'h0);
    rd(REG_CTRL, 32'h0);
    rd(REG_ACC, 32'h0);
    rd(REG_PADDR, 32'h0);
    $display("mid-run reset done");
    complete_run();
  end
  initial begin
    #2000000;
    fail_count++;
    complete_run();
  end
endmodule // testbench
